// File: core/hmpe_pkg.sv
// Package of constants and types for the host message poll and error unit.
package hmpe_pkg;
    // ****************************************************************
    // Command headers, two ASCII characters in one word.
    // ****************************************************************
    localparam logic [15:0] HDR_ERR = 16'h5858; // Error status message.
    localparam logic [15:0] HDR_SETUP = 16'h494D; // I/O format setup message.
    localparam logic [15:0] HDR_POLL = 16'h504C; // Poll request message.
    localparam logic [15:0] HDR_EMPTY = 16'h4E4D; // Empty queue reply.
    localparam logic [15:0] HDR_NOP = 16'h4E4F; // No operation message.
    // ****************************************************************
    // Configuration word layout.
    // ****************************************************************
    localparam int CFG_POLL = 0; // Polling mode.
    localparam int CFG_EMPTY = 1; // Empty-poll reply enable.
    localparam int CFG_IMAGE = 2; // Image data format.
    localparam int CFG_CHECK = 3; // Normal-running error detection enable, header check included.
    localparam int CFG_SPC_LSB = 8; // Special poll character, low bit.
    localparam int CFG_SPC_MSB = 14; // Special poll character, high bit.
    localparam logic [15:0] CFG_RESET = 16'h0000; // Value after reset.
    // ****************************************************************
    // Error status word layout.
    // ****************************************************************
    localparam int ERR_FMT = 3; // Malformed host message.
    localparam int ERR_INT = 7; // Unidentified internal interrupt.
    localparam int ERR_FULL = 10; // Serial buffer full.
    localparam int ERR_7_8 = 11; // Serial buffer seven-eighths full.
    localparam int ERR_HDR = 14; // Unrecognized command header.
    localparam logic [15:0] ERR_NOBUF_W1 = 16'h0100; // Buffer category word 1.
    localparam logic [15:0] ERR_OVR_W1 = 16'h0200; // Overrun category word 1.
    localparam logic [15:0] ERR_PORT_ID = 16'h0001; // Host serial port number.
    localparam logic [15:0] INT_ADDR_ADJ = 16'h0004; // Interrupt address offset.
    localparam logic [13:0] BANK_PAD = 14'h0000; // Low bits of word 3.
    localparam logic [47:0] EMPTY_BODY = 48'h000000000000; // Empty reply words.
    localparam logic [1:0] LAST_WORD = 2'h3; // Index of word 3.
    localparam int FIFO_DEPTH = 4; // Messages held in the output queue.
    localparam int MSG_W = 64; // Header plus three data words.
    // Transmit sequencer states.
    typedef enum logic [0:0] {
        HMPE_IDLE = 1'b0,
        HMPE_SEND = 1'b1
    } hmpe_tx_e;
endpackage : hmpe_pkg

// File: core/hmpe_unit.sv
// Output queue and the poll, setup and error message logic of the host link.
`timescale 1ns/1ps

// ********************************************************************
// Output queue of whole messages.
// ********************************************************************
module hmpe_fifo #(
    parameter int W = 64,
    parameter int D = 4
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = (D > 1) ? $clog2(D) : 1; // Pointer width.
    localparam logic [AW:0] FULL = (AW+1)'(D); // Count when full.
    // The pointers wrap by overflow, so the depth must be a power of two.
    if (D < 2 || (D & (D - 1)) != 0) begin : g_bad_depth
        $error("hmpe_fifo depth must be a power of two of at least 2.");
    end
    logic [W-1:0] mem [D]; // Message storage.
    logic [AW-1:0] wp, rp, next_wp, next_rp; // Write and read pointers.
    logic [AW:0] cnt, next_cnt; // Number of stored messages.
    logic push, pop; // Accepted transfers on each side.

    // Handshakes and next pointer values.
    always_comb begin
        in_ready_o = (cnt != FULL);
        out_valid_o = (cnt != '0);
        out_data_o = mem[rp];
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        next_wp = push ? AW'(wp + 1'b1) : wp;
        next_rp = pop ? AW'(rp + 1'b1) : rp;
        next_cnt = cnt;
        if (push && !pop) begin
            next_cnt = (AW+1)'(cnt + 1'b1);
        end else if (pop && !push) begin
            next_cnt = (AW+1)'(cnt - 1'b1);
        end
    end

    // Pointer and count registers.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            wp <= next_wp;
            rp <= next_rp;
            cnt <= next_cnt;
        end
    end

    // Storage is written without reset; empty entries are never read.
    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem[wp] <= in_data_i;
        end
    end
endmodule : hmpe_fifo

// ********************************************************************
// Top level of the message unit.
// ********************************************************************
module hmpe_unit (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic system_mode_i,
    input wire logic rx_valid_i,
    input wire logic rx_is_hdr_i,
    input wire logic [15:0] rx_word_i,
    input wire logic ext_hdr_known_i,
    input wire logic spc_valid_i,
    input wire logic [6:0] spc_char_i,
    input wire logic fmt_err_i,
    input wire logic int_err_i,
    input wire logic [15:0] int_addr_i,
    input wire logic sbuf_full_i,
    input wire logic sbuf_7_8_i,
    input wire logic no_buf_i,
    input wire logic [15:0] no_buf_hdr_i,
    input wire logic overrun_i,
    input wire logic [1:0] bank_i,
    input wire logic msg_valid_i,
    input wire logic [hmpe_pkg::MSG_W-1:0] msg_i,
    output logic msg_ready_o,
    output logic [15:0] cfg_o,
    output logic image_fmt_o,
    output logic queue_empty_o,
    output logic tx_valid_o,
    output logic [15:0] tx_word_o,
    output logic tx_last_o,
    input wire logic tx_ready_i
);
    import hmpe_pkg::*;

    // Picks word i of a message, header first.
    function automatic logic [15:0] hmpe_word(input logic [MSG_W-1:0] m, input logic [1:0] i);
        hmpe_word = m[(MSG_W - 1 - 16 * int'(i)) -: 16];
    endfunction : hmpe_word

    // ****************************************************************
    // Received header decoding and configuration.
    // ****************************************************************
    logic [15:0] cfg, next_cfg; // Configuration word.
    logic cfg_wait, next_cfg_wait; // Setup header seen, word expected.
    logic poll_hit, hdr_bad, hdr_known; // Decoded header events.

    // Setup capture and header classification.
    always_comb begin
        hdr_known = (rx_word_i == HDR_SETUP) || (rx_word_i == HDR_POLL)
            || (rx_word_i == HDR_NOP) || ext_hdr_known_i;
        poll_hit = rx_valid_i && rx_is_hdr_i && (rx_word_i == HDR_POLL);
        hdr_bad = rx_valid_i && rx_is_hdr_i && !hdr_known && cfg[CFG_CHECK];
        next_cfg = cfg;
        next_cfg_wait = cfg_wait;
        if (rx_valid_i && rx_is_hdr_i) begin
            next_cfg_wait = (rx_word_i == HDR_SETUP);
        end else if (rx_valid_i && cfg_wait) begin
            // The word after a setup header replaces the configuration.
            next_cfg = rx_word_i;
            next_cfg_wait = 1'b0;
        end
    end

    // Configuration registers; everything is off after reset.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg <= CFG_RESET;
            cfg_wait <= 1'b0;
        end else begin
            cfg <= next_cfg;
            cfg_wait <= next_cfg_wait;
        end
    end

    assign cfg_o = cfg;
    assign image_fmt_o = cfg[CFG_IMAGE];

    // ****************************************************************
    // Error collection and message building.
    // ****************************************************************
    logic [15:0] nr_w1, next_nr_w1, nr_w2, next_nr_w2; // Normal-running words.
    logic [15:0] nb_hdr, next_nb_hdr; // Header that found no buffer.
    logic nb_pend, next_nb_pend, ovr_pend, next_ovr_pend; // Pending categories.
    logic det, err_valid; // Detection active, an error message waits.
    logic [MSG_W-1:0] err_msg; // Error message offered to the queue.
    logic [15:0] bank_w; // Word 3 with the bank number.
    logic q_in_ready, q_out_valid, q_pop; // Queue handshakes.
    logic [MSG_W-1:0] q_out; // Oldest queued message.

    // Sticky error flags; a new event in the send cycle survives.
    always_comb begin
        det = system_mode_i && cfg[CFG_CHECK];
        bank_w = {bank_i, BANK_PAD};
        err_valid = ovr_pend || nb_pend || (nr_w1 != '0);
        // Overrun first, then buffer, then normal running.
        if (ovr_pend) begin
            err_msg = {HDR_ERR, ERR_OVR_W1, ERR_PORT_ID, bank_w};
        end else if (nb_pend) begin
            err_msg = {HDR_ERR, ERR_NOBUF_W1, nb_hdr, bank_w};
        end else begin
            err_msg = {HDR_ERR, nr_w1, nr_w2, bank_w};
        end
        next_nr_w1 = nr_w1;
        next_nr_w2 = nr_w2;
        next_nb_pend = nb_pend;
        next_nb_hdr = nb_hdr;
        next_ovr_pend = ovr_pend;
        // Clear the category just handed to the queue.
        if (err_valid && q_in_ready) begin
            if (ovr_pend) begin
                next_ovr_pend = 1'b0;
            end else if (nb_pend) begin
                next_nb_pend = 1'b0;
            end else begin
                next_nr_w1 = '0;
                next_nr_w2 = '0;
            end
        end
        // New events are applied after the clear so that they win.
        if (det) begin
            next_nr_w1[ERR_FMT] = next_nr_w1[ERR_FMT] | fmt_err_i;
            next_nr_w1[ERR_FULL] = next_nr_w1[ERR_FULL] | sbuf_full_i;
            next_nr_w1[ERR_7_8] = next_nr_w1[ERR_7_8] | sbuf_7_8_i;
            next_nr_w1[ERR_HDR] = next_nr_w1[ERR_HDR] | hdr_bad;
            if (int_err_i) begin
                next_nr_w1[ERR_INT] = 1'b1;
                next_nr_w2 = 16'(int_addr_i + INT_ADDR_ADJ);
            end
        end
        if (system_mode_i && no_buf_i) begin
            next_nb_pend = 1'b1;
            next_nb_hdr = no_buf_hdr_i;
        end
        if (system_mode_i && overrun_i) begin
            next_ovr_pend = 1'b1;
        end
    end

    // Error state registers.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            nr_w1 <= '0;
            nr_w2 <= '0;
            nb_hdr <= '0;
            nb_pend <= 1'b0;
            ovr_pend <= 1'b0;
        end else begin
            nr_w1 <= next_nr_w1;
            nr_w2 <= next_nr_w2;
            nb_hdr <= next_nb_hdr;
            nb_pend <= next_nb_pend;
            ovr_pend <= next_ovr_pend;
        end
    end

    // Error messages take the queue ahead of other traffic.
    assign msg_ready_o = q_in_ready && !err_valid;

    // Messages leave the queue in the order they entered.
    hmpe_fifo #(.W(MSG_W), .D(FIFO_DEPTH)) u_queue (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .in_valid_i(err_valid || msg_valid_i),
        .in_data_i(err_valid ? err_msg : msg_i),
        .in_ready_o(q_in_ready),
        .out_valid_o(q_out_valid),
        .out_data_o(q_out),
        .out_ready_i(q_pop)
    );

    assign queue_empty_o = !q_out_valid;

    // ****************************************************************
    // Poll handling and word transmission.
    // ****************************************************************
    hmpe_tx_e state, next_state; // Transmit sequencer state.
    logic grant, next_grant; // Host has asked for a message.
    logic spc_wait, next_spc_wait; // Poll seen, special character awaited.
    logic [MSG_W-1:0] msg, next_msg; // Message being sent.
    logic [1:0] idx, next_idx; // Word index within the message.
    logic [15:0] next_tx_word; // Next output word.
    logic spc_on, spc_match, go; // Special mode, release, start.

    // Decides when a message may leave and steps through its words.
    always_comb begin
        spc_on = cfg[CFG_POLL] && (cfg[CFG_SPC_MSB:CFG_SPC_LSB] != '0);
        spc_match = spc_valid_i && (spc_char_i == cfg[CFG_SPC_MSB:CFG_SPC_LSB]);
        next_grant = grant;
        next_spc_wait = spc_wait;
        if (poll_hit && cfg[CFG_POLL]) begin
            next_spc_wait = spc_on;
            next_grant = !spc_on;
        end else if (spc_wait && spc_match) begin
            next_spc_wait = 1'b0;
            next_grant = 1'b1;
        end
        // Bit 1 matters only while polling.
        go = !cfg[CFG_POLL] ? q_out_valid
            : (grant && (q_out_valid || cfg[CFG_EMPTY]));
        q_pop = 1'b0;
        next_state = state;
        next_msg = msg;
        next_idx = idx;
        next_tx_word = tx_word_o;
        case (state)
            HMPE_IDLE: begin
                if (go) begin
                    next_msg = q_out_valid ? q_out : {HDR_EMPTY, EMPTY_BODY};
                    q_pop = q_out_valid;
                    next_grant = 1'b0;
                    next_idx = '0;
                    next_tx_word = hmpe_word(next_msg, 2'h0);
                    next_state = HMPE_SEND;
                end
            end
            HMPE_SEND: begin
                if (tx_ready_i) begin
                    if (idx == LAST_WORD) begin
                        next_state = HMPE_IDLE;
                    end else begin
                        next_idx = 2'(idx + 2'h1);
                        next_tx_word = hmpe_word(msg, next_idx);
                    end
                end
            end
            default: begin
                next_state = HMPE_IDLE;
            end
        endcase
    end

    // Sequencer registers.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= HMPE_IDLE;
            grant <= 1'b0;
            spc_wait <= 1'b0;
            msg <= '0;
            idx <= '0;
            tx_word_o <= '0;
        end else begin
            state <= next_state;
            grant <= next_grant;
            spc_wait <= next_spc_wait;
            msg <= next_msg;
            idx <= next_idx;
            tx_word_o <= next_tx_word;
        end
    end

    assign tx_valid_o = (state == HMPE_SEND);
    assign tx_last_o = tx_valid_o && (idx == LAST_WORD);

    // ****************************************************************
    // Checks.
    // ****************************************************************
    a_setup_word: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        rx_valid_i && !rx_is_hdr_i && cfg_wait |=> cfg_o == $past(rx_word_i))
        else $error("Setup word not taken.");
    a_auto_send: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !cfg[CFG_POLL] && state == HMPE_IDLE && q_out_valid |=> tx_valid_o)
        else $error("Queued message not sent in non-polling mode.");
    a_poll_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        cfg[CFG_POLL] && !grant && state == HMPE_IDLE |=> !tx_valid_o)
        else $error("Message sent without a poll.");
    a_empty_reply: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        cfg[CFG_POLL] && cfg[CFG_EMPTY] && grant && !q_out_valid && state == HMPE_IDLE
        |=> tx_valid_o && tx_word_o == HDR_EMPTY ##1 (!$past(tx_ready_i) || tx_word_o == '0))
        else $error("Empty poll did not get the empty reply.");
    a_poll_wait: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        cfg[CFG_POLL] && !cfg[CFG_EMPTY] && grant && !q_out_valid && state == HMPE_IDLE
        |=> !tx_valid_o && grant)
        else $error("Poll on empty queue not held.");
    a_spc_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        spc_wait && !grant && !spc_match && !poll_hit |=> !grant)
        else $error("Message released without the special character.");
    a_whole_msg: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        tx_valid_o && !(tx_last_o && tx_ready_i) |=> tx_valid_o)
        else $error("Message cut short.");
    a_err_sticky: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        det && fmt_err_i |=> nr_w1[ERR_FMT] && err_valid)
        else $error("Format error lost.");
    a_ovr_word: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        ovr_pend |-> err_msg == {HDR_ERR, ERR_OVR_W1, ERR_PORT_ID, bank_i, BANK_PAD})
        else $error("Overrun message malformed.");
    a_int_addr: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        det && int_err_i |=> nr_w2 == 16'($past(int_addr_i) + INT_ADDR_ADJ))
        else $error("Interrupt address word wrong.");
endmodule : hmpe_unit

// File: dv/hmpe_host_model.sv
// Host computer model that takes the outgoing word stream of the unit.
`timescale 1ns/1ps
module hmpe_host_model (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic stall_i,
    input wire logic tx_valid_i,
    input wire logic [15:0] tx_word_i,
    input wire logic tx_last_i,
    output logic tx_ready_o,
    output logic [63:0] msg_o,
    output logic got_o
);
    logic [47:0] acc; // Words of the message taken so far, header first.
    // The host stalls only when a scenario asks it to.
    assign tx_ready_o = !stall_i;
    // ****************************************************************
    // Word collection.
    // ****************************************************************
    // Words are shifted in with the header first; the word flagged last closes a message.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            acc <= 48'h000000000000;
            msg_o <= 64'h0000000000000000;
            got_o <= 1'b0;
        end else begin
            got_o <= 1'b0;
            if (tx_valid_i && tx_ready_o) begin
                acc <= {acc[31:0], tx_word_i};
                if (tx_last_i) begin
                    msg_o <= {acc, tx_word_i};
                    got_o <= 1'b1;
                end
            end
        end
    end
endmodule : hmpe_host_model

// File: dv/hmpe_unit_test.sv
// Self-checking testbench of the host message poll and error unit.
`timescale 1ns/1ps
module hmpe_unit_test;
    import hmpe_pkg::*;
    logic ref_clk_i = 1'b0; // Clock at 250 MHz.
    logic rst_i = 1'b1; // Reset, held at the start.
    logic sys_mode = 1'b1; // System mode of the device.
    logic rx_valid = 1'b0, rx_is_hdr = 1'b0, ext_known = 1'b0, spc_valid = 1'b0;
    logic [15:0] rx_word = 16'h0000;
    logic [6:0] spc_char = 7'h00;
    logic [5:0] ev = 6'h00; // Events: format, interrupt, full, 7/8, overrun, no buffer.
    logic [15:0] int_addr = 16'h1230, nb_hdr = 16'h5249;
    logic [1:0] bank = 2'h2;
    logic msg_valid = 1'b0, stall = 1'b0;
    logic [63:0] msg = 64'h0;
    logic msg_ready, image_fmt, q_empty, tx_valid, tx_last, tx_ready, host_got;
    logic [15:0] cfg, tx_word;
    logic [63:0] host_msg;
    logic [63:0] log_q[$]; // Messages the host has received, oldest first.
    int err_total = 0;
    int total_checks = 0;
    always #2 ref_clk_i = ~ref_clk_i;
    hmpe_unit DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .system_mode_i(sys_mode),
        .rx_valid_i(rx_valid), .rx_is_hdr_i(rx_is_hdr), .rx_word_i(rx_word),
        .ext_hdr_known_i(ext_known), .spc_valid_i(spc_valid), .spc_char_i(spc_char),
        .fmt_err_i(ev[0]), .int_err_i(ev[1]), .int_addr_i(int_addr), .sbuf_full_i(ev[2]),
        .sbuf_7_8_i(ev[3]), .no_buf_i(ev[5]), .no_buf_hdr_i(nb_hdr), .overrun_i(ev[4]),
        .bank_i(bank), .msg_valid_i(msg_valid), .msg_i(msg), .msg_ready_o(msg_ready),
        .cfg_o(cfg), .image_fmt_o(image_fmt), .queue_empty_o(q_empty), .tx_valid_o(tx_valid),
        .tx_word_o(tx_word), .tx_last_o(tx_last), .tx_ready_i(tx_ready));
    hmpe_host_model host (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .stall_i(stall),
        .tx_valid_i(tx_valid), .tx_word_i(tx_word), .tx_last_i(tx_last),
        .tx_ready_o(tx_ready), .msg_o(host_msg), .got_o(host_got));
    // Each finished message is logged once, on the edge after its pulse.
    always @(posedge ref_clk_i) begin
        if (host_got === 1'b1) begin
            log_q.push_back(host_msg);
        end
    end
    // ****************************************************************
    // Shared tasks.
    // ****************************************************************
    // Compares a value seen with the value expected and counts both.
    task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Prints the counts and the verdict, then stops.
    task close_out;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out
    // Sends one received host word for one cycle.
    task rx(input logic hdr, input logic [15:0] w);
        @(posedge ref_clk_i);
        rx_valid <= 1'b1;
        rx_is_hdr <= hdr;
        rx_word <= w;
        @(posedge ref_clk_i);
        rx_valid <= 1'b0;
    endtask : rx
    // Writes the configuration word through a setup message.
    task setup(input logic [15:0] c);
        rx(1'b1, HDR_SETUP);
        rx(1'b0, c);
        repeat (2) @(posedge ref_clk_i);
        check("cfg", cfg, c);
    endtask : setup
    // Pulses a set of error events for one cycle.
    task pulse(input logic [5:0] v);
        @(posedge ref_clk_i);
        ev <= v;
        @(posedge ref_clk_i);
        ev <= 6'h00;
    endtask : pulse
    // Offers a message to the queue, holding it until taken or four edges pass.
    task push(input logic [63:0] m, output bit ok);
        @(posedge ref_clk_i);
        msg_valid <= 1'b1;
        msg <= m;
        ok = 1'b0;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge ref_clk_i);
            ok = (msg_ready === 1'b1);
        end
        msg_valid <= 1'b0;
    endtask : push
    // Waits a bounded time for the next message at the host and compares it.
    task expect_msg(input string what, input logic [63:0] m);
        for (int i = 0; i < 300 && log_q.size() == 0; i++) begin
            @(posedge ref_clk_i);
        end
        if (log_q.size() == 0) begin
            err_total++;
            $display("FAIL %s expected %h seen nothing", what, m);
        end else begin
            check(what, log_q.pop_front(), m);
        end
    endtask : expect_msg
    // Checks that nothing reaches the host for a while.
    task quiet(input string what);
        repeat (14) @(posedge ref_clk_i);
        check(what, {tx_valid, 32'(log_q.size())}, 64'h0);
    endtask : quiet
    // ****************************************************************
    // Scenarios.
    // ****************************************************************
    task t_setup;
        check("reset", {cfg, q_empty, tx_valid, msg_ready}, {16'h0000, 3'b101});
        setup(16'h0004);
        check("image", image_fmt, 1'b1);
        setup(16'h0000);
        check("packed", image_fmt, 1'b0);
        $display("test setup done");
    endtask : t_setup
    // Non-polling sends at once, in order; poll bits are ignored here.
    task t_nonpoll;
        bit ok;
        int acc;
        setup(16'h4102);
        push(64'h5251_0000_0000_0001, ok);
        push(64'h5251_0000_0000_0002, ok);
        expect_msg("auto first", 64'h5251_0000_0000_0001);
        expect_msg("auto second", 64'h5251_0000_0000_0002);
        stall <= 1'b1;
        acc = 0;
        for (int k = 0; k < 6; k++) begin
            push(64'h5251_0000_0000_0010 + 64'(k), ok);
            acc += int'(ok);
        end
        check("fill", 64'(acc), 64'd5);
        stall <= 1'b0;
        for (int k = 0; k < acc; k++) begin
            expect_msg("drain", 64'h5251_0000_0000_0010 + 64'(k));
        end
        repeat (4) @(posedge ref_clk_i);
        check("drained", q_empty, 1'b1);
        $display("test nonpoll done");
    endtask : t_nonpoll
    // Every error category, with the bank in word 3.
    task t_errors;
        setup(16'h0008);
        pulse(6'b001101);
        expect_msg("normal", 64'h5858_0C08_0000_8000);
        pulse(6'b000010);
        expect_msg("interrupt", 64'h5858_0080_1234_8000);
        @(posedge ref_clk_i);
        bank <= 2'h1;
        pulse(6'b010000);
        expect_msg("overrun", 64'h5858_0200_0001_4000);
        pulse(6'b100000);
        expect_msg("no buffer", 64'h5858_0100_5249_4000);
        rx(1'b1, 16'h4747);
        expect_msg("bad header", 64'h5858_4000_0000_4000);
        @(posedge ref_clk_i);
        ext_known <= 1'b1;
        rx(1'b1, 16'h4747);
        ext_known <= 1'b0;
        quiet("known header");
        sys_mode <= 1'b0;
        pulse(6'b010001);
        quiet("local mode");
        sys_mode <= 1'b1;
        setup(16'h0000);
        rx(1'b1, 16'h4747);
        pulse(6'b000001);
        quiet("detection off");
        $display("test errors done");
    endtask : t_errors
    // Polling, empty reply and special poll character.
    task t_poll;
        bit ok;
        setup(16'h0001);
        push(64'h5251_0000_0000_00A1, ok);
        quiet("held for poll");
        rx(1'b1, HDR_POLL);
        expect_msg("polled", 64'h5251_0000_0000_00A1);
        rx(1'b1, HDR_POLL);
        quiet("empty poll waits");
        push(64'h5251_0000_0000_00A2, ok);
        expect_msg("late", 64'h5251_0000_0000_00A2);
        setup(16'h0003);
        rx(1'b1, HDR_POLL);
        expect_msg("empty reply", {HDR_EMPTY, 48'h0});
        setup(16'h4101);
        push(64'h5251_0000_0000_00A3, ok);
        rx(1'b1, HDR_POLL);
        quiet("awaiting char");
        @(posedge ref_clk_i);
        spc_valid <= 1'b1;
        spc_char <= 7'h11;
        @(posedge ref_clk_i);
        spc_valid <= 1'b0;
        quiet("wrong char");
        spc_valid <= 1'b1;
        spc_char <= 7'h41;
        @(posedge ref_clk_i);
        spc_valid <= 1'b0;
        expect_msg("special", 64'h5251_0000_0000_00A3);
        $display("test poll done");
    endtask : t_poll
    // ****************************************************************
    // Sequence and watchdog.
    // ****************************************************************
    initial begin
        repeat (16) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        t_setup();
        t_nonpoll();
        t_errors();
        t_poll();
        close_out();
    end
    // The tests need a few hundred cycles; this cuts a hang short.
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        err_total++;
        $display("FAIL watchdog expected finish seen hang");
        close_out();
    end
endmodule : hmpe_unit_test
